// *** core/spfc_pkg.sv ***
// Shared constants and types for the stream packet format converter
package spfc_pkg;

    // ******************************************************************
    // Lane and packet geometry
    // ******************************************************************
    localparam int SYM_W     = 8;                     // Bits per symbol
    localparam int IN_SYM    = 2;                     // parallel_symbol_count, input side
    localparam int IN_LEN    = 2;                     // Beats per input packet
    localparam int IN_PKTS   = 1;                     // Input packets per frame (1: single-packet mode)
    localparam int OUT_SYM   = 1;                     // parallel_symbol_count, output side
    localparam int OUT_LEN   = 4;                     // Beats per output packet
    localparam int OUT_PKTS  = 1;                     // Output packets per frame
    localparam int SLOTS     = IN_SYM * IN_LEN * IN_PKTS;
    localparam int OUT_BEATS = OUT_LEN * OUT_PKTS;
    localparam int IN_BEATS  = IN_LEN * IN_PKTS;
    localparam int CNT_W     = 8;                     // Width of beat and packet counters
    localparam int EMPTY_W   = 1;                     // Width of the empty field

    // ******************************************************************
    // Handshake timing
    // ******************************************************************
    localparam int READY_LAT = 0;                     // Ready latency, 0 or 1 cycle

    // ******************************************************************
    // field_layout_list mapping: output slot k takes input slot FIELD_MAP[k]
    // Input order  I1 Q1 I2 Q2, output order I1 I2 Q1 Q2
    // ******************************************************************
    localparam int FIELD_MAP [SLOTS] = '{0, 2, 1, 3};

    // ******************************************************************
    // Reset values and types
    // ******************************************************************
    localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
    localparam logic [EMPTY_W-1:0] EMPTY_FULL = 1'h0;  // Every beat carries all lanes

    typedef enum logic [0:0] {
        ST_COLLECT,
        ST_EMIT
    } spfc_state_t;

endpackage

// *** core/spfc_stream_if.sv ***
// Streaming link between the converter and its upstream and downstream partners
`timescale 1ns/1ps
interface spfc_stream_if;
    // Input stream: partner is the source, converter the sink
    logic                                          in_valid;
    logic                                          in_ready;
    logic                                          in_sop;
    logic                                          in_eop;
    logic [spfc_pkg::EMPTY_W-1:0]                  in_empty;
    logic [spfc_pkg::IN_SYM*spfc_pkg::SYM_W-1:0]   in_data;
    // Output stream: converter is the source, partner the sink
    logic                                          out_valid;
    logic                                          out_ready;
    logic                                          out_sop;
    logic                                          out_eop;
    logic [spfc_pkg::EMPTY_W-1:0]                  out_empty;
    logic [spfc_pkg::OUT_SYM*spfc_pkg::SYM_W-1:0]  out_data;
    logic                                          out_error;

    modport conv (
        input  in_valid, in_sop, in_eop, in_empty, in_data, out_ready,
        output in_ready, out_valid, out_sop, out_eop, out_empty, out_data, out_error
    );

    modport peer (
        output in_valid, in_sop, in_eop, in_empty, in_data, out_ready,
        input  in_ready, out_valid, out_sop, out_eop, out_empty, out_data, out_error
    );
endinterface

// *** core/spfc_stream_peer.sv ***
// Partner end: upstream source feeding the converter and downstream sink draining it
`timescale 1ns/1ps
module spfc_stream_peer #(
    parameter int READY_LAT = spfc_pkg::READY_LAT
) (
    input  wire logic                                         SYS_CLK,
    input  wire logic                                         RST_N,
    spfc_stream_if.peer                                       LINK,
    input  wire logic                                         SRC_PUSH,
    input  wire logic [spfc_pkg::IN_SYM*spfc_pkg::SYM_W-1:0]  SRC_DATA,
    input  wire logic                                         SRC_SOP,
    input  wire logic                                         SRC_EOP,
    output logic                                              SRC_FREE,
    input  wire logic                                         SNK_HOLD,
    output logic                                              SNK_VALID,
    output logic [spfc_pkg::OUT_SYM*spfc_pkg::SYM_W-1:0]      SNK_DATA,
    output logic                                              SNK_SOP,
    output logic                                              SNK_EOP,
    output logic                                              SNK_ERROR
);
    // ******************************************************************
    // Source side state
    // ******************************************************************
    logic                                          full, next_full;
    logic                                          pres, next_pres;
    logic [spfc_pkg::IN_SYM*spfc_pkg::SYM_W-1:0]   hold_data, next_hold_data;
    logic                                          hold_sop, next_hold_sop;
    logic                                          hold_eop, next_hold_eop;
    logic                                          next_src_free;
    logic                                          taken;

    // Beat leaves the holder on the cycle the converter samples it
    assign taken = (READY_LAT == 0) ? (pres && LINK.in_ready) : pres;

    // Holder keeps data and valid steady until taken
    always_comb begin
        next_full      = full;
        next_hold_data = hold_data;
        next_hold_sop  = hold_sop;
        next_hold_eop  = hold_eop;
        if (taken) begin
            next_full = 1'b0;
        end
        if (SRC_PUSH && SRC_FREE) begin
            next_full      = 1'b1;
            next_hold_data = SRC_DATA;
            next_hold_sop  = SRC_SOP;
            next_hold_eop  = SRC_EOP;
        end
        // Latency 1 shows valid only one cycle after ready was seen
        if (READY_LAT == 0) begin
            next_pres = next_full;
        end else begin
            next_pres = full && !pres && LINK.in_ready;
        end
        next_src_free = !next_full;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            full      <= 1'b0;
            pres      <= 1'b0;
            hold_data <= '0;
            hold_sop  <= 1'b0;
            hold_eop  <= 1'b0;
            SRC_FREE  <= 1'b1;
        end else begin
            full      <= next_full;
            pres      <= next_pres;
            hold_data <= next_hold_data;
            hold_sop  <= next_hold_sop;
            hold_eop  <= next_hold_eop;
            SRC_FREE  <= next_src_free;
        end
    end

    assign LINK.in_valid = pres;
    assign LINK.in_data  = hold_data;
    assign LINK.in_sop   = hold_sop;
    assign LINK.in_eop   = hold_eop;
    assign LINK.in_empty = spfc_pkg::EMPTY_FULL;

    // ******************************************************************
    // Sink side: registered ready gives backpressure, capture per latency
    // ******************************************************************
    logic rdy, rdy_q, grab;

    assign grab = LINK.out_valid && ((READY_LAT == 0) ? rdy : rdy_q);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdy       <= 1'b0;
            rdy_q     <= 1'b0;
            SNK_VALID <= 1'b0;
            SNK_DATA  <= '0;
            SNK_SOP   <= 1'b0;
            SNK_EOP   <= 1'b0;
            SNK_ERROR <= 1'b0;
        end else begin
            rdy       <= !SNK_HOLD;
            rdy_q     <= rdy;
            SNK_VALID <= grab;
            SNK_DATA  <= grab ? LINK.out_data : SNK_DATA;
            SNK_SOP   <= grab ? LINK.out_sop : SNK_SOP;
            SNK_EOP   <= grab ? LINK.out_eop : SNK_EOP;
            SNK_ERROR <= grab ? LINK.out_error : SNK_ERROR;
        end
    end

    assign LINK.out_ready = rdy;

endmodule

// *** core/spfc_format_remapper.sv ***
// Converter end: collects input packets, remaps fields in time and lane, emits output packets
`timescale 1ns/1ps

module spfc_format_remapper #(
    parameter int READY_LAT = spfc_pkg::READY_LAT
) (
    input  wire logic  SYS_CLK,
    input  wire logic  RST_N,
    spfc_stream_if.conv LINK,
    output logic       BUSY,
    output logic       FRAME_DONE
);
    localparam int SW = spfc_pkg::SYM_W;
    localparam int CW = spfc_pkg::CNT_W;

    // ******************************************************************
    // Slot decoding
    // ******************************************************************
    // Flat slot index of a symbol lane within a frame
    function automatic int slot_of(input logic [CW-1:0] beat, input int lane, input int lanes);
        slot_of = int'(beat) * lanes + lane;
    endfunction

    // ******************************************************************
    // State
    // ******************************************************************
    spfc_pkg::spfc_state_t  state, next_state;
    logic [SW-1:0]          frame_buf [spfc_pkg::SLOTS];
    logic [SW-1:0]          next_frame_buf [spfc_pkg::SLOTS];
    logic [CW-1:0]          in_beat, next_in_beat;
    logic [CW-1:0]          in_pkt, next_in_pkt;
    logic [CW-1:0]          in_idx, next_in_idx;
    logic [CW-1:0]          out_beat, next_out_beat;
    logic [CW-1:0]          out_pkt, next_out_pkt;
    logic [CW-1:0]          out_idx, next_out_idx;
    logic                   frame_err, next_frame_err;
    logic                   in_rdy, next_in_rdy;
    logic                   in_rdy_q;
    logic                   o_valid, next_o_valid;
    logic                   o_sop, next_o_sop;
    logic                   o_eop, next_o_eop;
    logic                   o_err, next_o_err;
    logic [spfc_pkg::OUT_SYM*SW-1:0] o_data, next_o_data;
    logic                   next_busy;
    logic                   next_frame_done;
    logic                   accept;
    logic                   take;
    logic                   load;

    // Input beat sampled: latency 1 honours the ready shown one cycle earlier
    assign accept = (state == spfc_pkg::ST_COLLECT) && LINK.in_valid
                    && ((READY_LAT == 0) ? in_rdy : in_rdy_q);

    // Output beat consumed; with latency 1 every shown beat is taken
    assign take = (READY_LAT == 0) ? (o_valid && LINK.out_ready) : o_valid;

    // Next beat may be loaded once the current one has gone, or after ready for latency 1
    assign load = (state == spfc_pkg::ST_EMIT)
                  && ((READY_LAT == 0) ? (!o_valid || take) : LINK.out_ready);

    // ******************************************************************
    // Next-state logic
    // ******************************************************************
    // Collect a whole frame into slot storage, then replay it in the output order.
    // Storing the full frame trades flip-flops for a simple, exact remap of any layout.
    always_comb begin
        int   tgt;
        logic pkt_end;
        logic sop_bad;
        logic eop_bad;
        logic [CW-1:0] left;
        tgt             = 0;
        pkt_end         = 1'b0;
        sop_bad         = 1'b0;
        eop_bad         = 1'b0;
        left            = '0;
        next_state      = state;
        next_frame_buf  = frame_buf;
        next_in_beat    = in_beat;
        next_in_pkt     = in_pkt;
        next_in_idx     = in_idx;
        next_out_beat   = out_beat;
        next_out_pkt    = out_pkt;
        next_out_idx    = out_idx;
        next_frame_err  = frame_err;
        next_o_valid    = take ? 1'b0 : o_valid;
        next_o_sop      = o_sop;
        next_o_eop      = o_eop;
        next_o_err      = o_err;
        next_o_data     = o_data;
        next_frame_done = 1'b0;

        // Input side: store each lane in its slot and follow the packet markers
        if (accept) begin
            for (int s = 0; s < spfc_pkg::IN_SYM; s++) begin
                next_frame_buf[slot_of(in_idx, s, spfc_pkg::IN_SYM)] = LINK.in_data[s*SW +: SW];
            end
            pkt_end = LINK.in_eop || (in_beat == CW'(spfc_pkg::IN_LEN - 1));
            sop_bad = LINK.in_sop != (in_beat == '0);
            eop_bad = LINK.in_eop != (in_beat == CW'(spfc_pkg::IN_LEN - 1));
            if (sop_bad || eop_bad) begin
                next_frame_err = 1'b1;
            end
            if (pkt_end) begin
                // A short packet still closes; its missing slots keep stale data
                next_in_beat = '0;
                if (in_pkt == CW'(spfc_pkg::IN_PKTS - 1)) begin
                    next_in_pkt = '0;
                    next_in_idx = '0;
                    next_state  = spfc_pkg::ST_EMIT;
                end else begin
                    next_in_pkt = in_pkt + CW'(1);
                    next_in_idx = CW'((int'(in_pkt) + 1) * spfc_pkg::IN_LEN);
                end
            end else begin
                next_in_beat = in_beat + CW'(1);
                next_in_idx  = in_idx + CW'(1);
            end
        end

        // Output side: each lane fetches the mapped input slot
        if (load) begin
            next_o_valid = 1'b1;
            for (int s = 0; s < spfc_pkg::OUT_SYM; s++) begin
                tgt = spfc_pkg::FIELD_MAP[slot_of(out_idx, s, spfc_pkg::OUT_SYM)];
                next_o_data[s*SW +: SW] = frame_buf[tgt];
            end
            // A single output link makes every packet start aligned by construction
            next_o_sop = (out_beat == '0);
            next_o_eop = (out_beat == CW'(spfc_pkg::OUT_LEN - 1));
            next_o_err = frame_err;
            if (out_beat == CW'(spfc_pkg::OUT_LEN - 1)) begin
                next_out_beat = '0;
                if (out_pkt == CW'(spfc_pkg::OUT_PKTS - 1)) begin
                    // Frame fully replayed; the output side alone set its length
                    next_out_pkt    = '0;
                    next_out_idx    = '0;
                    next_frame_err  = 1'b0;
                    next_frame_done = 1'b1;
                    next_state      = spfc_pkg::ST_COLLECT;
                end else begin
                    next_out_pkt = out_pkt + CW'(1);
                    next_out_idx = out_idx + CW'(1);
                end
            end else begin
                next_out_beat = out_beat + CW'(1);
                next_out_idx  = out_idx + CW'(1);
            end
        end

        // Ready counts a beat already in flight under latency 1, so no beat
        // can land once the frame is full. An early end of packet under
        // latency 1 may still let one beat arrive, which is dropped.
        left = CW'(spfc_pkg::IN_BEATS) - next_in_idx;
        if (READY_LAT == 0) begin
            next_in_rdy = (next_state == spfc_pkg::ST_COLLECT);
        end else begin
            next_in_rdy = (next_state == spfc_pkg::ST_COLLECT)
                          && (left > CW'((in_rdy && !accept) ? 1 : 0));
        end
        next_busy = (next_state == spfc_pkg::ST_EMIT);
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    // Reset drops valid and error and clears every counter
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state      <= spfc_pkg::ST_COLLECT;
            for (int i = 0; i < spfc_pkg::SLOTS; i++) begin
                frame_buf[i] <= '0;
            end
            in_beat    <= spfc_pkg::CNT_RST;
            in_pkt     <= spfc_pkg::CNT_RST;
            in_idx     <= spfc_pkg::CNT_RST;
            out_beat   <= spfc_pkg::CNT_RST;
            out_pkt    <= spfc_pkg::CNT_RST;
            out_idx    <= spfc_pkg::CNT_RST;
            frame_err  <= 1'b0;
            in_rdy     <= 1'b0;
            in_rdy_q   <= 1'b0;
            o_valid    <= 1'b0;
            o_sop      <= 1'b0;
            o_eop      <= 1'b0;
            o_err      <= 1'b0;
            o_data     <= '0;
            BUSY       <= 1'b0;
            FRAME_DONE <= 1'b0;
        end else begin
            state      <= next_state;
            frame_buf  <= next_frame_buf;
            in_beat    <= next_in_beat;
            in_pkt     <= next_in_pkt;
            in_idx     <= next_in_idx;
            out_beat   <= next_out_beat;
            out_pkt    <= next_out_pkt;
            out_idx    <= next_out_idx;
            frame_err  <= next_frame_err;
            in_rdy     <= next_in_rdy;
            in_rdy_q   <= in_rdy;
            o_valid    <= next_o_valid;
            o_sop      <= next_o_sop;
            o_eop      <= next_o_eop;
            o_err      <= next_o_err;
            o_data     <= next_o_data;
            BUSY       <= next_busy;
            FRAME_DONE <= next_frame_done;
        end
    end

    // ******************************************************************
    // Link drive
    // ******************************************************************
    // Every output but the constant out_empty leaves straight from a flip-flop
    assign LINK.in_ready  = in_rdy;
    assign LINK.out_valid = o_valid;
    assign LINK.out_sop   = o_sop;
    assign LINK.out_eop   = o_eop;
    assign LINK.out_empty = spfc_pkg::EMPTY_FULL;
    assign LINK.out_data  = o_data;
    assign LINK.out_error = o_err;

endmodule

// *** bench/spfc_checker.sv ***
// Concurrent checks on the converter link
`timescale 1ns/1ps
module spfc_checker #(
    parameter int IW = spfc_pkg::IN_SYM * spfc_pkg::SYM_W,
    parameter int OW = spfc_pkg::OUT_SYM * spfc_pkg::SYM_W
) (
    input wire logic                         SYS_CLK,
    input wire logic                         RST_N,
    input wire logic                         in_valid,
    input wire logic                         in_ready,
    input wire logic                         in_sop,
    input wire logic                         in_eop,
    input wire logic [IW-1:0]                in_data,
    input wire logic                         out_valid,
    input wire logic                         out_ready,
    input wire logic                         out_sop,
    input wire logic                         out_eop,
    input wire logic [spfc_pkg::EMPTY_W-1:0] out_empty,
    input wire logic [OW-1:0]                out_data,
    input wire logic                         out_error
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // ******************************************************************
    // Reference counters; zero ready latency assumed
    // ******************************************************************
    logic [7:0]                 in_cnt;
    logic [7:0]                 out_cnt;
    logic                       err_acc;
    logic                       frame_err;
    logic [spfc_pkg::SYM_W-1:0] slot [spfc_pkg::SLOTS];
    wire  in_take  = in_valid && in_ready;
    wire  out_take = out_valid && out_ready;
    wire  bad      = (in_sop && in_cnt != 8'h00) || (in_eop && in_cnt != 8'(spfc_pkg::IN_BEATS - 1));

    // Beat positions and frame error; eop resyncs a short packet
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_cnt    <= 8'h00;
            out_cnt   <= 8'h00;
            err_acc   <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            if (in_take) begin
                in_cnt  <= in_eop ? 8'h00 : in_cnt + 8'h01;
                err_acc <= in_eop ? 1'b0 : (err_acc | bad);
                if (in_eop) begin
                    frame_err <= err_acc | bad;
                end
            end
            if (out_take) begin
                out_cnt <= out_eop ? 8'h00 : out_cnt + 8'h01;
            end
        end
    end

    // Input lanes; the guard keeps a long bad packet in range
    always_ff @(posedge SYS_CLK) begin
        if (in_take && in_cnt < 8'(spfc_pkg::IN_BEATS)) begin
            for (int s = 0; s < spfc_pkg::IN_SYM; s++) begin
                slot[in_cnt * spfc_pkg::IN_SYM + s] <= in_data[s*spfc_pkg::SYM_W +: spfc_pkg::SYM_W];
            end
        end
    end

    // ******************************************************************
    // Properties
    // ******************************************************************
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_sop) && $stable(out_eop);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output beat changed while stalled");
    property p_in_hold; in_valid && !in_ready |=> in_valid && $stable(in_data) && $stable(in_eop); endproperty
    a_in_hold: assert property (p_in_hold) else $error("input beat changed while stalled");
    property p_sop_pos; out_take && out_sop |-> out_cnt == 8'h00; endproperty
    a_sop_pos: assert property (p_sop_pos) else $error("output sop off beat zero");
    property p_eop_pos; out_take && out_eop |-> out_cnt == 8'(spfc_pkg::OUT_LEN - 1) && !out_sop; endproperty
    a_eop_pos: assert property (p_eop_pos) else $error("output eop off last beat");
    property p_map;
        out_take && !out_error && out_cnt < 8'(spfc_pkg::OUT_BEATS) |-> out_data == slot[spfc_pkg::FIELD_MAP[out_cnt]];
    endproperty
    a_map: assert property (p_map) else $error("output field taken from wrong slot");
    property p_err_val; out_take && out_sop |-> out_error == frame_err; endproperty
    a_err_val: assert property (p_err_val) else $error("frame error flag wrong");
    property p_err_keep; out_take && !out_eop |=> $stable(out_error); endproperty
    a_err_keep: assert property (p_err_keep) else $error("error flag changed inside frame");
    property p_ready_drop; in_take && in_eop |=> !in_ready; endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high after frame");
    property p_emit; in_take && in_eop |-> ##[1:4] (out_valid && out_sop); endproperty
    a_emit: assert property (p_emit) else $error("no output packet after input packet");
    property p_quiet; $rose(RST_N) |-> !out_valid && !out_error && out_empty == '0; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");

    // Main scenarios
    c_frame: cover property (out_take && out_eop);
    c_error: cover property (out_take && out_error);
    c_stall: cover property (out_valid && !out_ready);
endmodule

// *** bench/spfc_format_remapper_tb.sv ***
// Self-checking bench joining the converter to its partner end
`timescale 1ns/1ps
module spfc_format_remapper_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        src_push = 1'b0;
    logic [15:0] src_data = 16'h0000;
    logic        src_sop = 1'b0;
    logic        src_eop = 1'b0;
    logic        snk_hold = 1'b0;
    logic        stall_en = 1'b0;
    logic        src_free, snk_valid, snk_sop, snk_eop, snk_error, busy, frame_done;
    logic [7:0]  snk_data;
    logic [7:0]  b;
    logic [10:0] rx_q [$];
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n_done = 0;

    spfc_stream_if spfc_stream_if_i ();
    spfc_format_remapper spfc_format_remapper_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(spfc_stream_if_i),
        .BUSY(busy), .FRAME_DONE(frame_done));
    spfc_stream_peer spfc_stream_peer_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(spfc_stream_if_i),
        .SRC_PUSH(src_push), .SRC_DATA(src_data), .SRC_SOP(src_sop), .SRC_EOP(src_eop), .SRC_FREE(src_free),
        .SNK_HOLD(snk_hold), .SNK_VALID(snk_valid), .SNK_DATA(snk_data), .SNK_SOP(snk_sop), .SNK_EOP(snk_eop),
        .SNK_ERROR(snk_error));
    spfc_checker spfc_checker_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .in_valid(spfc_stream_if_i.in_valid),
        .in_ready(spfc_stream_if_i.in_ready), .in_sop(spfc_stream_if_i.in_sop), .in_eop(spfc_stream_if_i.in_eop),
        .in_data(spfc_stream_if_i.in_data), .out_valid(spfc_stream_if_i.out_valid),
        .out_ready(spfc_stream_if_i.out_ready), .out_sop(spfc_stream_if_i.out_sop),
        .out_eop(spfc_stream_if_i.out_eop), .out_empty(spfc_stream_if_i.out_empty),
        .out_data(spfc_stream_if_i.out_data), .out_error(spfc_stream_if_i.out_error));

    // ******************************************************************
    // Clock, stall pattern, receive monitor, timeout
    // ******************************************************************
    always #12.5 sys_clk = ~sys_clk;
    // Two-on two-off backpressure so stalls land on every beat position
    always @(negedge sys_clk) snk_hold <= stall_en & cyc[1];
    always @(posedge sys_clk) begin
        if (snk_valid === 1'b1) rx_q.push_back({snk_error, snk_sop, snk_eop, snk_data});
        if (frame_done === 1'b1) n_done++;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            finish_test();
        end
    end

    task automatic push_beat(input logic [15:0] d, input logic s, input logic e);
        int n = 0;
        while (src_free !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        src_push = 1'b1;
        src_data = d;
        src_sop = s;
        src_eop = e;
        @(negedge sys_clk);
        src_push = 1'b0;
    endtask

    // One received beat, {error, sop, eop, data}, under a mask
    task automatic check_beat(input logic [10:0] exp, input logic [10:0] m);
        logic [10:0] got;
        int          n = 0;
        while (rx_q.size() == 0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        got = (rx_q.size() > 0) ? rx_q.pop_front() : ~exp;
        total_checks++;
        if ((got & m) !== (exp & m)) begin
            fail_count++;
            $display("MISMATCH %0t beat got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    // Stale lanes of a broken frame are undefined; dm low masks data
    task automatic check_frame(input logic [31:0] d, input logic err, input logic dm);
        logic [10:0] m = {3'b111, {8{dm}}};
        check_beat({err, 2'b10, d[31:24]}, m);
        check_beat({err, 2'b00, d[23:16]}, m);
        check_beat({err, 2'b00, d[15:8]}, m);
        check_beat({err, 2'b01, d[7:0]}, m);
    endtask

    task automatic finish_test;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        check_bit(busy, 1'b0);
        check_bit(spfc_stream_if_i.out_error, 1'b0);
        push_beat(16'h2211, 1'b1, 1'b0);
        push_beat(16'h4433, 1'b0, 1'b1);
        check_frame(32'h11332244, 1'b0, 1'b1);
        // Three frames back to back under backpressure
        stall_en = 1'b1;
        for (int f = 1; f < 4; f++) begin
            b = 8'(16 * f);
            push_beat({b + 8'h02, b + 8'h01}, 1'b1, 1'b0);
            push_beat({b + 8'h04, b + 8'h03}, 1'b0, 1'b1);
        end
        for (int f = 1; f < 4; f++) begin
            b = 8'(16 * f);
            check_frame({b + 8'h01, b + 8'h03, b + 8'h02, b + 8'h04}, 1'b0, 1'b1);
        end
        stall_en = 1'b0;
        // Early eop, then stray sop, then a clean frame clears the flag
        push_beat(16'hBBAA, 1'b1, 1'b1);
        check_frame(32'h00000000, 1'b1, 1'b0);
        push_beat(16'hCCAA, 1'b1, 1'b0);
        push_beat(16'hDDEE, 1'b1, 1'b1);
        check_frame(32'h00000000, 1'b1, 1'b0);
        push_beat(16'h5655, 1'b1, 1'b0);
        push_beat(16'h5857, 1'b0, 1'b1);
        check_frame(32'h55575658, 1'b0, 1'b1);
        // Mid-packet reset drops the held beat
        push_beat(16'h6261, 1'b1, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_bit(busy, 1'b0);
        rst_n = 1'b1;
        push_beat(16'h7271, 1'b1, 1'b0);
        push_beat(16'h7473, 1'b0, 1'b1);
        check_frame(32'h71737274, 1'b0, 1'b1);
        repeat (10) @(negedge sys_clk);
        check_bit(rx_q.size() == 0, 1'b1);
        check_bit(n_done == 8, 1'b1);
        finish_test();
    end
endmodule
